// ### verilog/ebt_core.sv
// emulation break, trace, arm sequencer and i/o redirection map
//
// Function
// R1: route each i/o access per map setting
// R2: one setting per 64-byte-port block
// R3: map covers all 64K byte ports
// R4: console read stalls until operator data
// R5: handler gets port, direction, width; stalls
// R6: halt when execution reaches breakpoint address
// R7: break on range execute, access, read, write
// R8: resume continues exactly where it halted
// R9: trace every cycle unless qualified
// R10: armed conditions ignored until arm seen
// R11: four-state sequencer, four conditions each
// R12: reaching event count is a condition
// R13: reset and start clear sequencer, counts, arm; start sets arm when i_arm_use is low
// R14: host memory access adds 25 wait states
`timescale 1ns/10ps
module ebt_core
  import ebt_pkg::*;
#(
  parameter int unsigned HOST_WAIT_CYC = HOST_WAITS
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // emulation control
  input wire logic i_go,
  input wire logic i_resume,
  // processor bus cycle
  input wire logic i_cyc_valid,
  input wire logic i_cyc_fetch,
  input wire logic i_cyc_write,
  input wire logic i_cyc_io,
  input wire logic i_cyc_word,
  input wire logic [ADDR_W-1:0] i_cyc_addr,
  input wire logic [DATA_W-1:0] i_cyc_wdata,
  input wire logic [1:0] i_cyc_mem_src,
  // i/o map programming
  input wire logic i_map_we,
  input wire logic [BLK_IDX_W-1:0] i_map_blk,
  input wire logic [1:0] i_map_route,
  // console and handler answers
  input wire logic i_con_valid,
  input wire logic [DATA_W-1:0] i_con_data,
  input wire logic i_hnd_done,
  input wire logic [DATA_W-1:0] i_hnd_data,
  // event setup: conditions per sequencer state
  input wire logic [SEQ_STATES*SEQ_CONDS-1:0] i_c_en,
  input wire logic [SEQ_STATES*SEQ_CONDS*2-1:0] i_c_kind,
  input wire logic [SEQ_STATES*SEQ_CONDS*ADDR_W-1:0] i_c_lo,
  input wire logic [SEQ_STATES*SEQ_CONDS*ADDR_W-1:0] i_c_hi,
  input wire logic [CNT_W-1:0] i_evt_count,
  input wire logic i_arm_use,
  input wire logic i_brk_use_seq,
  input wire logic i_trc_qual,
  input wire logic [ADDR_W-1:0] i_bp_addr,
  input wire logic i_bp_en,
  // bus cycle answer
  output logic o_cyc_ready,
  output logic [DATA_W-1:0] o_cyc_rdata,
  output logic o_proto_io,
  // console and handler requests
  output logic o_con_req,
  output logic o_hnd_req,
  output logic [PORT_W-1:0] o_hnd_port,
  output logic o_hnd_write,
  output logic o_hnd_word,
  // status
  output logic o_halted,
  output logic o_running,
  output logic o_trace_we,
  output logic [ADDR_W-1:0] o_trace_addr,
  output logic o_armed,
  output logic [SEQ_W-1:0] o_seq_state
);
  localparam int unsigned NC = SEQ_STATES * SEQ_CONDS;
  logic [1:0] io_map [NUM_BLKS];
  ebt_state_t st_q, st_d;
  logic run_q, run_d;
  logic [SEQ_W-1:0] seq_q, seq_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic arm_q, arm_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic rdy_q, rdy_d;
  logic [DATA_W-1:0] rdat_q, rdat_d;
  logic con_q, con_d, hnd_q, hnd_d, pio_q, pio_d;
  logic trc_q, trc_d;
  logic [ADDR_W-1:0] taddr_q;
  logic halt_q, halt_d, hwr_q, hwd_q;
  logic [NC-1:0] hit;
  logic [1:0] route;
  logic seq_fire, seq_last, bp_hit, brk, run_cyc;
  logic [CNT_W-1:0] cnt_max;

  genvar g;
  generate
    for (g = 0; g < NC; g++) begin : g_cond
      ebt_cond u_cond (
        .i_en(i_c_en[g]),
        .i_kind(i_c_kind[g*2 +: 2]),
        .i_lo(i_c_lo[g*ADDR_W +: ADDR_W]),
        .i_hi(i_c_hi[g*ADDR_W +: ADDR_W]),
        .i_valid(i_cyc_valid),
        .i_fetch(i_cyc_fetch),
        .i_write(i_cyc_write),
        .i_addr(i_cyc_addr),
        .o_hit(hit[g])
      );
    end
  endgenerate

  // the map table is block-indexed, ports in a block share one route
  always_ff @(posedge i_sys_clk) begin
    if (i_map_we) begin
      io_map[i_map_blk] <= i_map_route; // R2 R3
    end
  end

  always_comb begin
    route = io_map[i_cyc_addr[BLK_SHIFT +: BLK_IDX_W]]; // R1 R2
    run_cyc = (st_q == ebt_run) && run_q && i_cyc_valid && !rdy_q;
    seq_fire = |hit[seq_q*SEQ_CONDS +: SEQ_CONDS]; // R11
    seq_last = (seq_q == SEQ_W'(SEQ_STATES - 1)) || (i_c_en[(seq_q+1)*SEQ_CONDS +: SEQ_CONDS] == '0);
    cnt_max = (i_evt_count == '0) ? CNT_W'(1) : i_evt_count;
    bp_hit = i_bp_en && i_cyc_fetch && (i_cyc_addr == i_bp_addr); // R6
    brk = 1'b0;
    st_d = st_q;
    run_d = run_q;
    seq_d = seq_q;
    cnt_d = cnt_q;
    arm_d = arm_q;
    wait_d = wait_q;
    rdy_d = 1'b0;
    rdat_d = rdat_q;
    con_d = con_q;
    hnd_d = hnd_q;
    pio_d = 1'b0;
    trc_d = 1'b0;
    if (i_go) begin
      run_d = 1'b1;
      st_d = ebt_run;
      seq_d = '0; // R13
      cnt_d = '0; // R13
      arm_d = !i_arm_use; // R13
    end else begin
      unique case (st_q)
        ebt_run: begin
          if (run_cyc) begin
            trc_d = !i_trc_qual || (arm_q && seq_fire); // R9 R10
            if (seq_fire) begin
              if (seq_last) begin
                if (cnt_q + CNT_W'(1) >= cnt_max) begin
                  cnt_d = '0; // R12
                  seq_d = '0;
                  if (!arm_q) begin
                    arm_d = 1'b1; // R10
                  end else if (i_brk_use_seq) begin
                    brk = 1'b1; // R11
                  end
                end else begin
                  cnt_d = cnt_q + CNT_W'(1); // R12
                  seq_d = '0;
                end
              end else begin
                seq_d = seq_q + SEQ_W'(1); // R11
              end
            end
            if (bp_hit && (arm_q || !i_arm_use)) begin
              brk = 1'b1; // R6 R10
            end
            if (brk) begin
              st_d = ebt_halt; // R8
            end else if (i_cyc_io) begin
              if (route == RT_CONSOLE && !i_cyc_write) begin
                st_d = ebt_io_wait;
                con_d = 1'b1; // R4
              end else if (route == RT_HANDLER || route == RT_MIX) begin
                st_d = ebt_io_wait;
                hnd_d = 1'b1; // R5
                pio_d = (route == RT_MIX);
              end else begin
                pio_d = 1'b1; // R1
                rdy_d = 1'b1;
              end
            end else if (i_cyc_mem_src == MEM_HOST) begin
              st_d = ebt_mem_wait;
              wait_d = WAIT_W'(HOST_WAIT_CYC - 1); // R14
            end else begin
              rdy_d = 1'b1; // R14
            end
          end
        end
        ebt_io_wait: begin
          if (con_q && i_con_valid) begin
            con_d = 1'b0;
            rdat_d = i_con_data; // R4
            rdy_d = 1'b1;
            st_d = ebt_run;
          end else if (hnd_q && i_hnd_done) begin
            hnd_d = 1'b0;
            rdat_d = i_hnd_data; // R5
            rdy_d = 1'b1;
            st_d = ebt_run;
          end
        end
        ebt_mem_wait: begin
          if (wait_q == '0) begin
            rdy_d = 1'b1; // R14
            st_d = ebt_run;
          end else begin
            wait_d = wait_q - WAIT_W'(1);
          end
        end
        ebt_halt: begin
          if (i_resume) begin
            st_d = ebt_run; // R8
            rdy_d = 1'b1;
          end
        end
      endcase
    end
    halt_d = (st_d == ebt_halt);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ebt_halt;
      run_q <= 1'b0;
      seq_q <= '0; // R13
      cnt_q <= '0;
      arm_q <= 1'b0;
      wait_q <= '0;
      rdy_q <= 1'b0;
      rdat_q <= '0;
      con_q <= 1'b0;
      hnd_q <= 1'b0;
      pio_q <= 1'b0;
      trc_q <= 1'b0;
      taddr_q <= '0;
      halt_q <= 1'b1;
      hwr_q <= 1'b0;
      hwd_q <= 1'b0;
    end else begin
      st_q <= st_d;
      run_q <= run_d;
      seq_q <= seq_d;
      cnt_q <= cnt_d;
      arm_q <= arm_d;
      wait_q <= wait_d;
      rdy_q <= rdy_d;
      rdat_q <= rdat_d;
      con_q <= con_d;
      hnd_q <= hnd_d;
      pio_q <= pio_d;
      trc_q <= trc_d;
      taddr_q <= i_cyc_addr;
      halt_q <= halt_d;
      hwr_q <= i_cyc_write; // R5
      hwd_q <= i_cyc_word; // R5
    end
  end

  always_comb begin
    o_cyc_ready = rdy_q;
    o_cyc_rdata = rdat_q;
    o_proto_io = pio_q;
    o_con_req = con_q;
    o_hnd_req = hnd_q;
    o_hnd_port = taddr_q[PORT_W-1:0]; // R5
    o_hnd_write = hwr_q;
    o_hnd_word = hwd_q;
    o_halted = halt_q;
    o_running = run_q;
    o_trace_we = trc_q;
    o_trace_addr = taddr_q;
    o_armed = arm_q;
    o_seq_state = seq_q;
  end
  default clocking dcb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  chk_ready_pulse: assert property (rdy_q |=> !rdy_q) else $error("ready held"); // R4
  chk_go_clears: assert property (i_go |=> (seq_q == '0 && cnt_q == '0)) else $error("go"); // R13
  chk_host_wait: assert property (st_q == ebt_mem_wait && wait_q != '0 |=> !rdy_q) else $error("wait"); // R14
  chk_break_halts: assert property (run_cyc && brk && !i_go |=> halt_q) else $error("no halt"); // R6
  chk_unarmed_run: assert property (st_q == ebt_run && !arm_q && i_arm_use && !i_go |=> !halt_q) else $error("armed"); // R10
  chk_trace_all: assert property (run_cyc && !i_trc_qual && !i_go |=> trc_q) else $error("trace"); // R9
  cov_console: cover property (con_q && i_con_valid);
  cov_handler: cover property (hnd_q && i_hnd_done);
  cov_break: cover property (run_cyc && brk);
endmodule // ebt_core

// ### verilog/ebt_pkg.sv
// package: constants and types for the emulation break, trace and i/o map block
package ebt_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BLK_BYTE_PORTS = 64;
  localparam int unsigned BLK_SHIFT = $clog2(BLK_BYTE_PORTS);
  localparam int unsigned NUM_BLKS = (1 << PORT_W) / BLK_BYTE_PORTS;
  localparam int unsigned BLK_IDX_W = PORT_W - BLK_SHIFT;
  localparam int unsigned SEQ_STATES = 4;
  localparam int unsigned SEQ_CONDS = 4;
  localparam int unsigned SEQ_W = $clog2(SEQ_STATES);
  localparam int unsigned CNT_W = 16;
  localparam int unsigned HOST_WAITS = 25;
  localparam int unsigned WAIT_W = 5;
  localparam logic [1:0] RT_PROTO = 2'h0;
  localparam logic [1:0] RT_CONSOLE = 2'h1;
  localparam logic [1:0] RT_HANDLER = 2'h2;
  localparam logic [1:0] RT_MIX = 2'h3;
  localparam logic [1:0] MEM_EMU = 2'h0;
  localparam logic [1:0] MEM_PROTO = 2'h1;
  localparam logic [1:0] MEM_HOST = 2'h2;
  localparam logic [1:0] BRK_EXEC = 2'h0;
  localparam logic [1:0] BRK_ACCESS = 2'h1;
  localparam logic [1:0] BRK_READ = 2'h2;
  localparam logic [1:0] BRK_WRITE = 2'h3;
  typedef enum logic [1:0] {ebt_run, ebt_io_wait, ebt_mem_wait, ebt_halt} ebt_state_t;
endpackage

// ### verilog/ebt_cond.sv
// address range condition unit used by the break, arm and trace matchers
`timescale 1ns/10ps
module ebt_cond
  import ebt_pkg::*;
(
  // match setup
  input wire logic i_en,
  input wire logic [1:0] i_kind,
  input wire logic [ADDR_W-1:0] i_lo,
  input wire logic [ADDR_W-1:0] i_hi,
  // observed cycle
  input wire logic i_valid,
  input wire logic i_fetch,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  // result
  output logic o_hit
);
  logic in_range;
  logic kind_ok;
  always_comb begin
    in_range = (i_addr >= i_lo) && (i_addr <= i_hi);
    unique case (i_kind)
      BRK_EXEC: kind_ok = i_fetch;
      BRK_ACCESS: kind_ok = 1'b1;
      BRK_READ: kind_ok = !i_fetch && !i_write;
      BRK_WRITE: kind_ok = i_write;
    endcase
    o_hit = i_en && i_valid && in_range && kind_ok; // R6 R7
  end
endmodule // ebt_cond

// ### bench/ebt_cpu_model.sv
// bus cycle model of the emulated processor
`timescale 1ns/10ps
module ebt_cpu_model
  import ebt_pkg::*;
(
  // clock and answer
  input wire logic i_sys_clk,
  input wire logic i_cyc_ready,
  input wire logic [DATA_W-1:0] i_cyc_rdata,
  // cycle request
  output logic o_valid,
  output logic [3:0] o_kind,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  output logic [1:0] o_src
);
  initial begin
    o_valid = 1'b0;
    o_kind = 4'h0;
    o_addr = '0;
    o_wdata = '0;
    o_src = 2'h0;
  end
  // kind is {fetch, write, io, word}; n counts waited cycles, capped at 40
  task automatic bus(input logic [3:0] k, input logic [ADDR_W-1:0] a,
      input logic [1:0] s, output logic [DATA_W-1:0] q, output int n);
    n = 0;
    @(negedge i_sys_clk);
    o_valid = 1'b1;
    o_kind = k;
    o_addr = a;
    o_wdata = a[DATA_W-1:0] ^ 16'hc3a5;
    o_src = s;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (i_cyc_ready !== 1'b1 && n < 40);
    q = i_cyc_rdata;
    @(negedge i_sys_clk);
    o_valid = 1'b0;
    // released address and data lines show the inverse, not the last value
    o_addr = ~a;
    o_wdata = ~o_wdata;
  endtask
endmodule // ebt_cpu_model

// ### bench/tb.sv
// self-checking bench for the break, trace and i/o map core
`timescale 1ns/10ps
module tb;
  import ebt_pkg::*;
  localparam int unsigned WAITS = 2;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_go = 1'b0, i_resume = 1'b0;
  logic i_map_we = 1'b0, i_con_valid = 1'b0, i_hnd_done = 1'b0;
  logic [BLK_IDX_W-1:0] i_map_blk = '0;
  logic [1:0] i_map_route = 2'h0, i_cyc_mem_src;
  logic [DATA_W-1:0] i_con_data = '0, i_hnd_data = '0, i_cyc_wdata, o_cyc_rdata, q;
  logic [SEQ_STATES*SEQ_CONDS-1:0] i_c_en = '0;
  logic [SEQ_STATES*SEQ_CONDS*2-1:0] i_c_kind = '0;
  logic [SEQ_STATES*SEQ_CONDS*ADDR_W-1:0] i_c_lo = '0, i_c_hi = '0;
  logic [CNT_W-1:0] i_evt_count = '0;
  logic i_arm_use = 1'b0, i_brk_use_seq = 1'b0, i_trc_qual = 1'b0, i_bp_en = 1'b0;
  logic [ADDR_W-1:0] i_bp_addr = '0, i_cyc_addr, o_trace_addr, last_trc = '0;
  logic i_cyc_valid, o_cyc_ready, o_proto_io, o_con_req, o_hnd_req, o_hnd_write, o_hnd_word;
  logic o_halted, o_running, o_trace_we, o_armed, saw_proto = 1'b0;
  logic [3:0] kind;
  logic [PORT_W-1:0] o_hnd_port;
  logic [SEQ_W-1:0] o_seq_state;
  int errors = 0, samples_checked = 0, cycles = 0, n;
  always #20 i_sys_clk = ~i_sys_clk;
  ebt_cpu_model ebt_cpu_model_inst (.i_sys_clk, .i_cyc_ready(o_cyc_ready),
    .i_cyc_rdata(o_cyc_rdata), .o_valid(i_cyc_valid), .o_kind(kind), .o_addr(i_cyc_addr),
    .o_wdata(i_cyc_wdata), .o_src(i_cyc_mem_src));
  ebt_core #(.HOST_WAIT_CYC(WAITS)) ebt_core_inst (.i_sys_clk, .i_rst_n, .i_go, .i_resume,
    .i_cyc_valid, .i_cyc_fetch(kind[3]), .i_cyc_write(kind[2]), .i_cyc_io(kind[1]),
    .i_cyc_word(kind[0]), .i_cyc_addr, .i_cyc_wdata, .i_cyc_mem_src, .i_map_we, .i_map_blk,
    .i_map_route, .i_con_valid, .i_con_data, .i_hnd_done, .i_hnd_data, .i_c_en, .i_c_kind,
    .i_c_lo, .i_c_hi, .i_evt_count, .i_arm_use, .i_brk_use_seq, .i_trc_qual, .i_bp_addr,
    .i_bp_en, .o_cyc_ready, .o_cyc_rdata, .o_proto_io, .o_con_req, .o_hnd_req, .o_hnd_port,
    .o_hnd_write, .o_hnd_word, .o_halted, .o_running, .o_trace_we, .o_trace_addr, .o_armed,
    .o_seq_state);
  always @(posedge i_sys_clk) begin
    if (o_proto_io === 1'b1) saw_proto <= 1'b1;
    if (o_trace_we === 1'b1) last_trc <= o_trace_addr;
  end
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step(ref logic s);
    @(negedge i_sys_clk);
    s = 1'b1;
    @(negedge i_sys_clk);
    s = 1'b0;
  endtask
  task automatic map(input int b, input logic [1:0] r);
    @(negedge i_sys_clk);
    i_map_we = 1'b1;
    i_map_blk = BLK_IDX_W'(b);
    i_map_route = r;
    @(negedge i_sys_clk);
    i_map_we = 1'b0;
  endtask
  // console or handler answers after a stall of three cycles
  task automatic answer(input bit h, input logic [DATA_W-1:0] v, input logic [15:0] p,
      input logic [3:0] c);
    int k;
    for (k = 0; k < 30 && (h ? o_hnd_req : o_con_req) !== 1'b1; k++) @(negedge i_sys_clk);
    chk(k < 30, 1, "request");
    if (h) chk(o_hnd_port, p, "port");
    if (h) chk({o_hnd_write, o_hnd_word}, {c[2], c[0]}, "dir width");
    repeat (3) @(negedge i_sys_clk);
    i_con_data = v;
    i_hnd_data = v;
    if (h) step(i_hnd_done);
    else step(i_con_valid);
  endtask
  task automatic io(input logic [3:0] c, input logic [15:0] p, input int h,
      input logic [DATA_W-1:0] v);
    fork
      ebt_cpu_model_inst.bus(c, {4'h0, p}, MEM_EMU, q, n);
      if (h >= 0) answer(h[0], v, p, c);
    join
    if (h >= 0) chk(q, v, "port data");
    if (h >= 0) chk(n > 4, 1, "stall");
  endtask
  task automatic t_io();
    map(0, RT_CONSOLE);
    map(1, RT_HANDLER);
    map(2, RT_PROTO);
    map(NUM_BLKS - 1, RT_HANDLER);
    io(4'h2, 16'h003f, 0, 16'h5a3c);
    io(4'h2, 16'h0040, 1, 16'h1234);
    io(4'h7, 16'hfffe, 1, 16'h8001);
    saw_proto = 1'b0;
    io(4'h2, 16'h0080, -1, 16'h0000);
    chk(saw_proto, 1, "proto");
    $display("test io done");
  endtask
  task automatic t_mem();
    ebt_cpu_model_inst.bus(4'h0, 20'h01000, MEM_HOST, q, n);
    chk(n > WAITS, 1, "host wait");
    ebt_cpu_model_inst.bus(4'h8, 20'h02345, MEM_EMU, q, n);
    chk(n < 3, 1, "real time");
    chk(last_trc, 20'h02345, "trace");
    i_trc_qual = 1'b1;
    ebt_cpu_model_inst.bus(4'h8, 20'h03456, MEM_PROTO, q, n);
    chk(last_trc, 20'h02345, "qualified");
    i_trc_qual = 1'b0;
    $display("test mem done");
  endtask
  task automatic t_brk();
    i_bp_addr = 20'h04000;
    i_bp_en = 1'b1;
    ebt_cpu_model_inst.bus(4'h8, 20'h04000, MEM_EMU, q, n);
    chk(o_halted, 1, "break");
    i_bp_en = 1'b0;
    step(i_resume);
    chk({o_halted, o_running}, 1, "resume");
    ebt_cpu_model_inst.bus(4'h8, 20'h04002, MEM_EMU, q, n);
    chk(n < 3, 1, "continue");
    i_arm_use = 1'b1;
    step(i_go);
    chk({o_armed, o_seq_state}, 0, "cleared");
    i_bp_en = 1'b1;
    ebt_cpu_model_inst.bus(4'h8, 20'h04000, MEM_EMU, q, n);
    chk(o_halted, 0, "unarmed");
    i_arm_use = 1'b0;
    i_bp_en = 1'b0;
    step(i_go);
    i_c_en = 16'h0001;
    i_c_kind[1:0] = BRK_EXEC;
    i_c_lo[ADDR_W-1:0] = 20'h06000;
    i_c_hi[ADDR_W-1:0] = 20'h06000;
    i_evt_count = 16'h0002;
    i_brk_use_seq = 1'b1;
    ebt_cpu_model_inst.bus(4'h8, 20'h06000, MEM_EMU, q, n);
    chk(o_halted, 0, "first event");
    ebt_cpu_model_inst.bus(4'h8, 20'h06000, MEM_EMU, q, n);
    chk(o_halted, 1, "count");
    $display("test break done");
  endtask
  initial begin
    repeat (20) @(negedge i_sys_clk);
    chk(o_halted, 1, "reset halt");
    chk({o_running, o_armed, o_cyc_ready, o_trace_we, o_con_req}, 0, "reset");
    i_rst_n = 1'b1;
    step(i_go);
    chk(o_running, 1, "run");
    t_io();
    t_mem();
    t_brk();
    stop_test();
  end
endmodule // tb
